/* design/lmo_pkg.sv */
// Summary of operation
// - Row force-on bits close row supply switch
// - Row 1-6 mask bits open supply switch
// - Row 7-9 mask bits open supply switch
// - All override bits reset zero, normal scanning
// - Double bit makes fade-out one or two base times
// - Double bit also doubles duty fade-out
// - Bits 3-2 select low slope extension
// - Bits 1-0 select high slope extension
// - Base phase time comes from per-LED register
// - Per-LED mode resolved by fixed priority
// - Host master accesses registers by sub-address
`default_nettype none
package lmo_pkg;

  // ----------------------------------------
  // Register sub-addresses
  // ----------------------------------------
  localparam logic [7:0] LMO_ADDR_COL_LO = 8'h2c; // Column 1-6 override
  localparam logic [7:0] LMO_ADDR_COL_HI = 8'h2d; // Column 7-10 override
  localparam logic [7:0] LMO_ADDR_ON_LO = 8'h2e;  // Row 1-6 force-on
  localparam logic [7:0] LMO_ADDR_ON_HI = 8'h2f;  // Row 7-9 force-on
  localparam logic [7:0] LMO_ADDR_OFF_LO = 8'h30; // Row 1-6 force-off
  localparam logic [7:0] LMO_ADDR_OFF_HI = 8'h31; // Row 7-9 force-off
  localparam logic [7:0] LMO_ADDR_SLOPE = 8'h32;  // Fade slope timing

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam logic [7:0] LMO_RESET_VALUE = 8'h00; // Every register
  localparam int LMO_COL_LO_W = 6;   // Columns in low register
  localparam int LMO_COL_HI_W = 4;   // Columns in high register
  localparam int LMO_ROW_LO_W = 6;   // Rows in low register
  localparam int LMO_ROW_HI_W = 3;   // Rows in high register
  localparam int LMO_FADE_DBL_BIT = 4; // Fade-out double bit
  localparam int LMO_LOW_EXT_LSB = 2;  // Low slope extension field
  localparam int LMO_HIGH_EXT_LSB = 0; // High slope extension field
  localparam int LMO_EXT_W = 2;        // Width of each extension field
  localparam int LMO_SLOPE_W = 5;      // Used bits of slope register

  // ----------------------------------------
  // Matrix geometry
  // ----------------------------------------
  localparam int LMO_ROWS = 9;   // Row outputs
  localparam int LMO_COLS = 10;  // Column outputs
  localparam int LMO_LEDS = LMO_ROWS * LMO_COLS; // Row-major LED index
  localparam int LMO_CUR_W = 4;  // Per-LED current setting width

  // Register access from the serial slave, same clock
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmo_bus_s;

  // Resolved LED operating mode
  typedef enum logic [5:0] {
    LMO_MODE_OFF = 6'h01,
    LMO_MODE_COL_CONST = 6'h02,
    LMO_MODE_ROW_ON = 6'h04,
    LMO_MODE_DUTY = 6'h08,
    LMO_MODE_BLINK = 6'h10,
    LMO_MODE_CONST = 6'h20
  } lmo_mode_e;

endpackage
`default_nettype wire

/* design/lmo_led_mode.sv */
`timescale 1ns/10ps
`default_nettype none
module lmo_led_mode
  import lmo_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic matrix_enable,
  input wire logic col_const,
  input wire logic row_off,
  input wire logic row_on,
  input wire logic duty_en,
  input wire logic blink_nz,
  output lmo_mode_e mode
);

  // ----------------------------------------
  // Priority resolve, one LED
  // ----------------------------------------
  lmo_mode_e next_mode; // Combinational pick

  // Earlier terms win over later ones
  always_comb begin
    if (!matrix_enable) begin
      next_mode = LMO_MODE_OFF;
    end else if (col_const) begin
      next_mode = LMO_MODE_COL_CONST;
    end else if (row_off) begin
      next_mode = LMO_MODE_OFF;
    end else if (row_on) begin
      next_mode = LMO_MODE_ROW_ON;
    end else if (duty_en) begin
      next_mode = LMO_MODE_DUTY;
    end else if (blink_nz) begin
      next_mode = LMO_MODE_BLINK;
    end else begin
      next_mode = LMO_MODE_CONST;
    end
  end

  // Registered so the scan engine sees a clean code
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= LMO_MODE_OFF;
    end else begin
      mode <= next_mode;
    end
  end

endmodule
`default_nettype wire

/* design/lmo_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module lmo_regs
  import lmo_pkg::*;
#(
  parameter int T1W = 8 // Width of a phase time count
) (
  input wire logic mclk,
  input wire logic reset_n,
  // Register access from the serial slave
  input wire lmo_bus_s reg_req,
  output logic [7:0] reg_rdata,
  // Scan engine inputs
  input wire logic matrix_enable,
  input wire logic [LMO_LEDS-1:0] duty_enable,
  input wire logic [LMO_LEDS-1:0] blink_nonzero,
  input wire logic [LMO_COLS*LMO_CUR_W-1:0] first_row_current,
  input wire logic [T1W-1:0] base_phase_time,
  input wire logic [T1W-1:0] duty_fade_in,
  // Override state towards the matrix
  output logic [LMO_COLS-1:0] column_const_current,
  output logic [LMO_COLS*LMO_CUR_W-1:0] column_current,
  output logic [LMO_ROWS-1:0] row_force_on,
  output logic [LMO_ROWS-1:0] row_force_off,
  output lmo_mode_e [LMO_LEDS-1:0] led_mode,
  // Fade engine timing
  output logic fade_out_double,
  output logic [LMO_EXT_W-1:0] low_slope_extension,
  output logic [LMO_EXT_W-1:0] high_slope_extension,
  output logic [T1W:0] fade_out_phase,
  output logic [T1W:0] duty_fade_out
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic wr_col_lo; // Write strobes per register
  logic wr_col_hi;
  logic wr_on_lo;
  logic wr_on_hi;
  logic wr_off_lo;
  logic wr_off_hi;
  logic wr_slope;

  // Each sub-address selects exactly one register
  assign wr_col_lo = reg_req.wr && (reg_req.addr == LMO_ADDR_COL_LO);
  assign wr_col_hi = reg_req.wr && (reg_req.addr == LMO_ADDR_COL_HI);
  assign wr_on_lo = reg_req.wr && (reg_req.addr == LMO_ADDR_ON_LO);
  assign wr_on_hi = reg_req.wr && (reg_req.addr == LMO_ADDR_ON_HI);
  assign wr_off_lo = reg_req.wr && (reg_req.addr == LMO_ADDR_OFF_LO);
  assign wr_off_hi = reg_req.wr && (reg_req.addr == LMO_ADDR_OFF_HI);
  assign wr_slope = reg_req.wr && (reg_req.addr == LMO_ADDR_SLOPE);

  // ----------------------------------------
  // Column override bits
  // ----------------------------------------
  // Upper data bits are simply not stored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      column_const_current <= '0;
    end else begin
      if (wr_col_lo) begin
        column_const_current[LMO_COL_LO_W-1:0] <=
          reg_req.wdata[LMO_COL_LO_W-1:0];
      end
      if (wr_col_hi) begin
        column_const_current[LMO_COLS-1:LMO_COL_LO_W] <=
          reg_req.wdata[LMO_COL_HI_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Column current source
  // ----------------------------------------
  // A forced column borrows the setting of the first-row LED
  // with the same index; others show zero so nothing leaks
  genvar gc;
  generate
    for (gc = 0; gc < LMO_COLS; gc++) begin : g_col
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          column_current[gc*LMO_CUR_W +: LMO_CUR_W] <= '0;
        end else if (column_const_current[gc]) begin
          column_current[gc*LMO_CUR_W +: LMO_CUR_W] <=
            first_row_current[gc*LMO_CUR_W +: LMO_CUR_W];
        end else begin
          column_current[gc*LMO_CUR_W +: LMO_CUR_W] <= '0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Row force-on bits
  // ----------------------------------------
  // Set bit closes the row supply switch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      row_force_on <= '0;
    end else begin
      if (wr_on_lo) begin
        row_force_on[LMO_ROW_LO_W-1:0] <=
          reg_req.wdata[LMO_ROW_LO_W-1:0];
      end
      if (wr_on_hi) begin
        row_force_on[LMO_ROWS-1:LMO_ROW_LO_W] <=
          reg_req.wdata[LMO_ROW_HI_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Row force-off bits
  // ----------------------------------------
  // Set bit opens the row supply switch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      row_force_off <= '0;
    end else begin
      if (wr_off_lo) begin
        row_force_off[LMO_ROW_LO_W-1:0] <=
          reg_req.wdata[LMO_ROW_LO_W-1:0];
      end
      if (wr_off_hi) begin
        row_force_off[LMO_ROWS-1:LMO_ROW_LO_W] <=
          reg_req.wdata[LMO_ROW_HI_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Slope timing register
  // ----------------------------------------
  // Extension codes have no decoded meaning here; they go
  // to the fade engine exactly as written
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fade_out_double <= 1'b0;
      low_slope_extension <= '0;
      high_slope_extension <= '0;
    end else if (wr_slope) begin
      fade_out_double <= reg_req.wdata[LMO_FADE_DBL_BIT];
      low_slope_extension <=
        reg_req.wdata[LMO_LOW_EXT_LSB +: LMO_EXT_W];
      high_slope_extension <=
        reg_req.wdata[LMO_HIGH_EXT_LSB +: LMO_EXT_W];
    end
  end

  // ----------------------------------------
  // Fade-out lengths
  // ----------------------------------------
  // One extra bit so the doubled time never wraps
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fade_out_phase <= '0;
      duty_fade_out <= '0;
    end else begin
      // Base time is the per-LED value, never the slope register
      fade_out_phase <= fade_out_double ?
        {base_phase_time, 1'b0} : {1'b0, base_phase_time};
      duty_fade_out <= fade_out_double ?
        {duty_fade_in, 1'b0} : {1'b0, duty_fade_in};
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  logic [7:0] next_rdata; // Selected read value

  // Unmapped addresses and unused bits read zero
  always_comb begin
    next_rdata = LMO_RESET_VALUE;
    unique case (reg_req.addr)
      LMO_ADDR_COL_LO: begin
        next_rdata[LMO_COL_LO_W-1:0] =
          column_const_current[LMO_COL_LO_W-1:0];
      end
      LMO_ADDR_COL_HI: begin
        next_rdata[LMO_COL_HI_W-1:0] =
          column_const_current[LMO_COLS-1:LMO_COL_LO_W];
      end
      LMO_ADDR_ON_LO: begin
        next_rdata[LMO_ROW_LO_W-1:0] = row_force_on[LMO_ROW_LO_W-1:0];
      end
      LMO_ADDR_ON_HI: begin
        next_rdata[LMO_ROW_HI_W-1:0] =
          row_force_on[LMO_ROWS-1:LMO_ROW_LO_W];
      end
      LMO_ADDR_OFF_LO: begin
        next_rdata[LMO_ROW_LO_W-1:0] = row_force_off[LMO_ROW_LO_W-1:0];
      end
      LMO_ADDR_OFF_HI: begin
        next_rdata[LMO_ROW_HI_W-1:0] =
          row_force_off[LMO_ROWS-1:LMO_ROW_LO_W];
      end
      LMO_ADDR_SLOPE: begin
        next_rdata[LMO_FADE_DBL_BIT] = fade_out_double;
        next_rdata[LMO_LOW_EXT_LSB +: LMO_EXT_W] = low_slope_extension;
        next_rdata[LMO_HIGH_EXT_LSB +: LMO_EXT_W] = high_slope_extension;
      end
      default: begin
        next_rdata = LMO_RESET_VALUE; // Outside this group
      end
    endcase
  end

  // Data held until the next read so a slow slave can shift it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= LMO_RESET_VALUE;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Per-LED mode resolve
  // ----------------------------------------
  // LED index is row * columns + column
  genvar gl;
  generate
    for (gl = 0; gl < LMO_LEDS; gl++) begin : g_led
      lmo_led_mode lmo_led_mode_inst (
        .mclk(mclk),
        .reset_n(reset_n),
        .matrix_enable(matrix_enable),
        .col_const(column_const_current[gl % LMO_COLS]),
        .row_off(row_force_off[gl / LMO_COLS]),
        .row_on(row_force_on[gl / LMO_COLS]),
        .duty_en(duty_enable[gl]),
        .blink_nz(blink_nonzero[gl]),
        .mode(led_mode[gl])
      );
    end
  endgenerate

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_col_lo_write: assert property (wr_col_lo |=>
    column_const_current[5:0] == $past(reg_req.wdata[5:0]))
    else $error("column low override not stored");

  a_col_hi_write: assert property (wr_col_hi |=>
    column_const_current[9:6] == $past(reg_req.wdata[3:0]))
    else $error("column high override not stored");

  a_row_on_write: assert property ((wr_on_lo && !wr_on_hi) |=>
    row_force_on[5:0] == $past(reg_req.wdata[5:0]) &&
    $stable(row_force_on[8:6]))
    else $error("row force-on low not stored");

  a_row_off_low: assert property (wr_off_lo |=>
    row_force_off[5:0] == $past(reg_req.wdata[5:0]))
    else $error("row force-off low not stored");

  a_row_off_high: assert property (wr_off_hi |=>
    row_force_off[8:6] == $past(reg_req.wdata[2:0]))
    else $error("row force-off high not stored");

  a_reset_clear: assert property ($rose(reset_n) |->
    column_const_current == '0 && row_force_on == '0 &&
    row_force_off == '0 && !fade_out_double)
    else $error("override bits not clear after reset");

  a_fade_out_len: assert property (##1 $past(reset_n) |->
    fade_out_phase == ($past(fade_out_double) ?
    {$past(base_phase_time), 1'b0} : {1'b0, $past(base_phase_time)}))
    else $error("fade-out phase not one or two base times");

  a_duty_fade_len: assert property (fade_out_double ##1
    $stable(fade_out_double) |-> duty_fade_out == {$past(duty_fade_in), 1'b0})
    else $error("duty fade-out not doubled");

  a_slope_fields: assert property (wr_slope |=>
    low_slope_extension == $past(reg_req.wdata[3:2]) &&
    high_slope_extension == $past(reg_req.wdata[1:0]))
    else $error("slope extension fields not passed as written");

  a_upper_zero: assert property (reg_req.rd &&
    reg_req.addr == LMO_ADDR_ON_HI |=> reg_rdata[7:3] == 5'h00)
    else $error("unused upper bits read nonzero");

  a_mode_off: assert property (!matrix_enable |=>
    led_mode[0] == LMO_MODE_OFF && led_mode[LMO_LEDS-1] == LMO_MODE_OFF)
    else $error("LED not off with matrix disabled");

  a_mode_col_wins: assert property (matrix_enable &&
    column_const_current[0] && row_force_off[0] |=>
    led_mode[0] == LMO_MODE_COL_CONST)
    else $error("column override lost priority");

  a_read_back: assert property (reg_req.rd && !reg_req.wr &&
    reg_req.addr == LMO_ADDR_OFF_LO |=>
    reg_rdata == {2'b00, $past(row_force_off[5:0])})
    else $error("row force-off read-back mismatch");

  c_row_on_mode: cover property (matrix_enable && row_force_on[0] &&
    !row_force_off[0] && !column_const_current[0] ##1
    led_mode[0] == LMO_MODE_ROW_ON);
  c_fade_double: cover property (wr_slope && reg_req.wdata[4] ##1
    fade_out_double);
  c_blink_mode: cover property (led_mode[5] == LMO_MODE_BLINK);
  c_unmapped_read: cover property (reg_req.rd && reg_req.addr == 8'h33);

endmodule
`default_nettype wire

/* dv/lmo_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lmo_host_model
  import lmo_pkg::*;
(
  input wire logic mclk,
  output var lmo_bus_s reg_req,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------
  // Serial master side of the register port
  // ----------------------------------------
  // Idle bus at time zero
  initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

  // One byte access by sub-address, strobe held across one rising edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge mclk);
    reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge mclk);
    // Read data registered at the taking edge
    q = reg_rdata;
    // Released fields flip so stale values cannot pass for valid ones
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

/* dv/lmo_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module lmo_regs_bench;
  import lmo_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int T1W = 8; // Phase time width
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  lmo_bus_s reg_req;
  logic [7:0] reg_rdata;
  logic matrix_enable = 1'b0;
  logic [LMO_LEDS-1:0] duty_enable = '0;
  logic [LMO_LEDS-1:0] blink_nonzero = '0;
  logic [LMO_COLS*LMO_CUR_W-1:0] first_row_current = '0;
  logic [T1W-1:0] base_phase_time = '0;
  logic [T1W-1:0] duty_fade_in = '0;
  logic [LMO_COLS-1:0] column_const_current;
  logic [LMO_COLS*LMO_CUR_W-1:0] column_current;
  logic [LMO_ROWS-1:0] row_force_on;
  logic [LMO_ROWS-1:0] row_force_off;
  lmo_mode_e [LMO_LEDS-1:0] led_mode;
  logic fade_out_double;
  logic [LMO_EXT_W-1:0] low_slope_extension;
  logic [LMO_EXT_W-1:0] high_slope_extension;
  logic [T1W:0] fade_out_phase;
  logic [T1W:0] duty_fade_out;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  // Bench copy of the register contents
  logic [9:0] m_col = '0;
  logic [8:0] m_on = '0;
  logic [8:0] m_off = '0;
  logic [4:0] m_slope = '0;

  always #5 mclk = ~mclk;

  lmo_regs #(.T1W(T1W)) lmo_regs_inst (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .matrix_enable(matrix_enable), .duty_enable(duty_enable),
    .blink_nonzero(blink_nonzero), .first_row_current(first_row_current),
    .base_phase_time(base_phase_time), .duty_fade_in(duty_fade_in),
    .column_const_current(column_const_current), .column_current(column_current),
    .row_force_on(row_force_on), .row_force_off(row_force_off), .led_mode(led_mode),
    .fade_out_double(fade_out_double), .low_slope_extension(low_slope_extension),
    .high_slope_extension(high_slope_extension), .fade_out_phase(fade_out_phase),
    .duty_fade_out(duty_fade_out));

  lmo_host_model lmo_host_model_inst (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  // Readback with unused upper bits as zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      LMO_ADDR_COL_LO: exp_rd = {2'b00, m_col[5:0]};
      LMO_ADDR_COL_HI: exp_rd = {4'h0, m_col[9:6]};
      LMO_ADDR_ON_LO: exp_rd = {2'b00, m_on[5:0]};
      LMO_ADDR_ON_HI: exp_rd = {5'h00, m_on[8:6]};
      LMO_ADDR_OFF_LO: exp_rd = {2'b00, m_off[5:0]};
      LMO_ADDR_OFF_HI: exp_rd = {5'h00, m_off[8:6]};
      LMO_ADDR_SLOPE: exp_rd = {3'h0, m_slope};
      default: exp_rd = 8'h00;
    endcase
  endfunction

  // Fade-out length: same as the input or twice it
  function automatic logic [T1W:0] dbl(input logic [T1W-1:0] t);
    dbl = m_slope[4] ? {t, 1'b0} : {1'b0, t};
  endfunction

  // Priority resolution for one LED, row-major index
  function automatic lmo_mode_e exp_mode(input int i);
    int r;
    int c;
    r = i / LMO_COLS;
    c = i % LMO_COLS;
    if (!matrix_enable) exp_mode = LMO_MODE_OFF;
    else if (m_col[c]) exp_mode = LMO_MODE_COL_CONST;
    else if (m_off[r]) exp_mode = LMO_MODE_OFF;
    else if (m_on[r]) exp_mode = LMO_MODE_ROW_ON;
    else if (duty_enable[i]) exp_mode = LMO_MODE_DUTY;
    else if (blink_nonzero[i]) exp_mode = LMO_MODE_BLINK;
    else exp_mode = LMO_MODE_CONST;
  endfunction

  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_all();
    logic [39:0] cur;
    for (int c = 0; c < LMO_COLS; c++) begin
      // Forced column takes the first-row setting of its index
      cur[c*4 +: 4] = m_col[c] ? first_row_current[c*4 +: 4] : 4'h0;
    end
    chk("column_const_current", m_col, column_const_current);
    chk("column_current", cur, column_current);
    chk("row_force_on", m_on, row_force_on);
    chk("row_force_off", m_off, row_force_off);
    chk("fade_out_double", m_slope[4], fade_out_double);
    chk("low_slope_extension", m_slope[3:2], low_slope_extension);
    chk("high_slope_extension", m_slope[1:0], high_slope_extension);
    chk("fade_out_phase", dbl(base_phase_time), fade_out_phase);
    chk("duty_fade_out", dbl(duty_fade_in), duty_fade_out);
    for (int i = 0; i < LMO_LEDS; i++) begin
      chk("led_mode", exp_mode(i), led_mode[i]);
    end
  endtask

  // Write one byte and mirror it in the bench copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    lmo_host_model_inst.access(1'b1, a, d, q);
    case (a)
      LMO_ADDR_COL_LO: m_col[5:0] = d[5:0];
      LMO_ADDR_COL_HI: m_col[9:6] = d[3:0];
      LMO_ADDR_ON_LO: m_on[5:0] = d[5:0];
      LMO_ADDR_ON_HI: m_on[8:6] = d[2:0];
      LMO_ADDR_OFF_LO: m_off[5:0] = d[5:0];
      LMO_ADDR_OFF_HI: m_off[8:6] = d[2:0];
      LMO_ADDR_SLOPE: m_slope = d[4:0];
      default: ; // Unmapped write has no effect
    endcase
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] q;
    lmo_host_model_inst.access(1'b0, a, 8'h00, q);
    chk("reg_rdata", exp_rd(a), q);
  endtask

  // Read every place from one below the group to one above it
  task automatic read_all();
    for (int a = 8'h2b; a <= 8'h33; a++) begin
      rd_chk(8'(a));
    end
  endtask

  // ----------------------------------------
  // Closing and hang guard
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Run needs well under 5000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      $display("[FAIL] run_length expected finish seen timeout");
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h82a9));
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    check_all();
    read_all();
    // Corner: all ones, longest phase time, then random traffic
    for (int a = 8'h2c; a <= 8'h32; a++) wr(8'(a), 8'hff);
    base_phase_time = 8'hff;
    duty_fade_in = 8'hff;
    matrix_enable = 1'b1;
    repeat (3) @(negedge mclk);
    check_all();
    read_all();
    for (int n = 0; n < 60; n++) begin
      @(negedge mclk);
      matrix_enable = ($urandom() % 8) != 0;
      duty_enable = LMO_LEDS'({$urandom(), $urandom(), $urandom()});
      blink_nonzero = LMO_LEDS'({$urandom(), $urandom(), $urandom()});
      first_row_current = 40'({$urandom(), $urandom()});
      base_phase_time = 8'($urandom());
      duty_fade_in = 8'($urandom());
      wr(8'(8'h2b + $urandom() % 9), 8'($urandom()));
      repeat (3) @(negedge mclk);
      check_all();
      rd_chk(8'(8'h2b + $urandom() % 9));
    end
    // Reset in mid-run clears every bit
    @(negedge mclk);
    reset_n = 1'b0;
    m_col = '0;
    m_on = '0;
    m_off = '0;
    m_slope = '0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    check_all();
    read_all();
    give_verdict();
  end
endmodule
`default_nettype wire
